// ---- rtl/qeh_pkg.sv ----
package qeh_pkg;
  // Clocking and rates
  localparam int CLK_HZ = 125_000_000;
  localparam int MAX_COUNT_HZ = 12_000_000;
  localparam int CYCLES_PER_COUNT = CLK_HZ / MAX_COUNT_HZ;
  localparam int SAMPLE_HZ = 2048;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  // Bus
  localparam int AXI_AW = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_POS = 8'h08;
  localparam logic [7:0] OFF_HOME_VAL = 8'h0C;
  localparam logic [7:0] OFF_CMD_POS = 8'h10;
  localparam logic [7:0] OFF_ERROR = 8'h14;
  localparam logic [7:0] OFF_KP = 8'h18;
  localparam logic [7:0] OFF_KI = 8'h1C;
  localparam logic [7:0] OFF_KD = 8'h20;
  localparam logic [7:0] OFF_PID_OUT = 8'h24;
  localparam logic [7:0] OFF_SLIP_LIM = 8'h28;
  localparam logic [7:0] OFF_GEAR = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_MASK = 8'h34;
  localparam logic [7:0] OFF_STATE = 8'h38;
  localparam logic [7:0] OFF_CORR = 8'h3C;
  // Control bits
  localparam int CTRL_INDEX_MODE = 0;
  localparam int CTRL_HOME_HIGH = 1;
  localparam int CTRL_INV_A = 2;
  localparam int CTRL_INV_B = 3;
  localparam int CTRL_SWAP = 4;
  localparam int CTRL_STOP_NOW = 5;
  localparam int CTRL_DIR_NEG = 6;
  localparam int CTRL_SERVO = 7;
  localparam int CTRL_SLIP_EN = 8;
  localparam int CTRL_GEAR_EN = 9;
  localparam int CTRL_CORR_EN = 10;
  localparam int CTRL_W = 11;
  // Command bits
  localparam int CMD_SEEK = 0;
  localparam int CMD_ABORT = 1;
  // Status bits
  localparam int ST_HOME = 0;
  localparam int ST_SLIP = 1;
  localparam int ST_CORR = 2;
  localparam int ST_QERR = 3;
  localparam int ST_W = 4;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
  localparam logic [15:0] GEAR_RESET = 16'h0100;
  localparam logic [31:0] SLIP_RESET = 32'h0000_0100;
  // Fixed-point scaling of filter and gearing
  localparam int PID_SHIFT = 8;
  localparam int GEAR_SHIFT = 8;
  typedef enum logic [1:0] {HOME_IDLE = 2'b00, HOME_SEEK = 2'b01, HOME_STOP = 2'b11} qeh_home_e;
  typedef enum logic [1:0] {PH_00 = 2'b00, PH_10 = 2'b10, PH_11 = 2'b11, PH_01 = 2'b01} qeh_phase_e;
endpackage : qeh_pkg

// ---- rtl/qeh_sync.sv ----
`timescale 1ns/1ns
module qeh_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : qeh_sync

// ---- rtl/qeh_quad.sv ----
`timescale 1ns/1ns
module qeh_quad (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Conditioned phases
  input wire logic pa,
  input wire logic pb,
  // Count pulses
  output logic up,
  output logic down,
  output logic err
);
  qeh_pkg::qeh_phase_e state;
  qeh_pkg::qeh_phase_e fwd;
  qeh_pkg::qeh_phase_e rev;
  logic primed;
  wire [1:0] ph_in = {pa, pb};
  wire is_fwd = primed && (ph_in == fwd);
  wire is_rev = primed && (ph_in == rev);
  // Both phases moving at once has no direction; it is flagged, never counted
  wire is_bad = primed && (ph_in != state) && !is_fwd && !is_rev;

  always_comb begin
    case (state)
      qeh_pkg::PH_00: begin
        fwd = qeh_pkg::PH_10;
        rev = qeh_pkg::PH_01;
      end
      qeh_pkg::PH_10: begin
        fwd = qeh_pkg::PH_11;
        rev = qeh_pkg::PH_00;
      end
      qeh_pkg::PH_11: begin
        fwd = qeh_pkg::PH_01;
        rev = qeh_pkg::PH_10;
      end
      default: begin
        fwd = qeh_pkg::PH_00;
        rev = qeh_pkg::PH_11;
      end
    endcase
  end

  // Every legal edge of either phase is one count: four per line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= qeh_pkg::PH_00;
      primed <= 1'b0;
      up <= 1'b0;
      down <= 1'b0;
      err <= 1'b0;
    end else begin
      primed <= 1'b1;
      if (!primed || is_fwd || is_rev) begin
        state <= qeh_pkg::qeh_phase_e'(ph_in);
      end
      up <= is_fwd;
      down <= is_rev;
      err <= is_bad;
    end
  end
endmodule : qeh_quad

// ---- rtl/qeh_axis.sv ----
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
// Contract
// - Phase A and B are decoded times four, giving four counts per encoder line.
// - The counter takes up to 12 MHz of counts after decoding without dropping any.
// - On servo axes the position error is computed continuously and drives the output through a PID filter.
// - On stepper axes the error can be applied as a position correction once the move has finished.
// - Slip or stall detection and geared encoder tracking are selectable in every mode, and the count is readable.
// - Homing is by switch or by index, and switch homing is selected after reset.
// - In switch homing the home input is selectable as active high or active low.
// - When home is detected during a seek the position counter is loaded with the chosen home value.
// - On home detection the axis either ramps to a stop or halts at once, as configured.
// - Home travel direction, home active level and stop response are each configurable.
// - Index homing fires only when index, the low-true home enable and the A-and-B-high quadrant coincide.
// - Either phase may be inverted and the phases swapped, each of which reverses counting.
// - Wiring and phase settings must make the count rise on positive moves.
module qeh_axis #(
  parameter int SAMPLE_CYCLES = qeh_pkg::SAMPLE_CYCLES,
  parameter int OUT_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [qeh_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [qeh_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Encoder and home pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  input wire logic home_switch,
  input wire logic home_enable_n,
  // Motion profile
  input wire logic move_done,
  // Axis outputs
  output logic signed [OUT_W-1:0] servo_out,
  output logic home_dir,
  output logic homing_active,
  output logic stop_ramp,
  output logic stop_now,
  output logic correct_valid,
  output logic [31:0] correct_steps,
  output logic [31:0] gear_position,
  output logic irq
);
  // Registers
  logic [qeh_pkg::CTRL_W-1:0] ctrl;
  logic [31:0] position;
  logic [31:0] home_value;
  logic [31:0] cmd_pos;
  logic [15:0] kp;
  logic [15:0] ki;
  logic [15:0] kd;
  logic [31:0] slip_limit;
  logic [15:0] gear_ratio;
  logic [qeh_pkg::ST_W-1:0] status;
  logic [qeh_pkg::ST_W-1:0] irq_mask;
  qeh_pkg::qeh_home_e home_state;

  // Input conditioning
  logic [4:0] pins_s;
  logic qa;
  logic qb;
  logic cnt_up;
  logic cnt_down;
  logic cnt_err;
  logic hit_d;

  qeh_sync #(
    .W(5)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({home_enable_n, home_switch, enc_index, enc_b, enc_a}),
    .q(pins_s)
  );

  wire ph_a = pins_s[0] ^ ctrl[qeh_pkg::CTRL_INV_A];
  wire ph_b = pins_s[1] ^ ctrl[qeh_pkg::CTRL_INV_B];
  assign qa = ctrl[qeh_pkg::CTRL_SWAP] ? ph_b : ph_a;
  assign qb = ctrl[qeh_pkg::CTRL_SWAP] ? ph_a : ph_b;

  qeh_quad u_quad (
    .aclk(aclk),
    .aresetn(aresetn),
    .pa(qa),
    .pb(qb),
    .up(cnt_up),
    .down(cnt_down),
    .err(cnt_err)
  );

  // Home detection
  wire index_mode = ctrl[qeh_pkg::CTRL_INDEX_MODE];
  wire sw_hit = (pins_s[3] == ctrl[qeh_pkg::CTRL_HOME_HIGH]);
  wire idx_hit = qa && qb && pins_s[2] && !pins_s[4];
  wire home_hit = index_mode ? idx_hit : sw_hit;
  // Edge, not level: a switch already active at seek start must be left first
  wire home_edge = home_hit && !hit_d;
  wire seeking = (home_state == qeh_pkg::HOME_SEEK);
  wire home_found = seeking && home_edge;

  // Bus decode
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && !s_axi_rvalid;
  wire [7:0] wa = {s_axi_awaddr[7:2], 2'b00};
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire w_ctrl = wr_go && (wa == qeh_pkg::OFF_CTRL);
  wire w_cmd = wr_go && (wa == qeh_pkg::OFF_CMD);
  wire w_pos = wr_go && (wa == qeh_pkg::OFF_POS);
  wire w_hval = wr_go && (wa == qeh_pkg::OFF_HOME_VAL);
  wire w_cpos = wr_go && (wa == qeh_pkg::OFF_CMD_POS);
  wire w_kp = wr_go && (wa == qeh_pkg::OFF_KP);
  wire w_ki = wr_go && (wa == qeh_pkg::OFF_KI);
  wire w_kd = wr_go && (wa == qeh_pkg::OFF_KD);
  wire w_slip = wr_go && (wa == qeh_pkg::OFF_SLIP_LIM);
  wire w_gear = wr_go && (wa == qeh_pkg::OFF_GEAR);
  wire w_stat = wr_go && (wa == qeh_pkg::OFF_STATUS);
  wire w_mask = wr_go && (wa == qeh_pkg::OFF_MASK);
  wire w_known = w_ctrl || w_cmd || w_pos || w_hval || w_cpos || w_kp || w_ki || w_kd || w_slip
    || w_gear || w_stat || w_mask;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wbits = s_axi_wdata & wmask;
  wire seek_req = w_cmd && wbits[qeh_pkg::CMD_SEEK];
  wire abort_req = w_cmd && wbits[qeh_pkg::CMD_ABORT];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  // Sample-rate divider shared by filter and slip check
  logic [31:0] tick_cnt;
  wire tick = (tick_cnt == 32'(SAMPLE_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    end
  end

  // Error and filter
  logic signed [31:0] integ;
  logic signed [31:0] err_prev;
  wire signed [31:0] err_now = $signed(cmd_pos) - $signed(position);
  wire signed [31:0] err_diff = err_now - err_prev;
  wire signed [47:0] p_term = $signed(kp) * err_now;
  wire signed [47:0] i_term = $signed(ki) * integ;
  wire signed [47:0] d_term = $signed(kd) * err_diff;
  wire signed [49:0] pid_sum = 50'(p_term) + 50'(i_term) + 50'(d_term);
  wire signed [49:0] pid_scaled = pid_sum >>> qeh_pkg::PID_SHIFT;
  wire signed [49:0] out_max = 50'((1 <<< (OUT_W - 1)) - 1);
  wire signed [49:0] out_min = -out_max - 50'sd1;
  wire signed [OUT_W-1:0] pid_sat = (pid_scaled > out_max) ? OUT_W'(out_max)
    : (pid_scaled < out_min) ? OUT_W'(out_min) : OUT_W'(pid_scaled);
  wire servo = ctrl[qeh_pkg::CTRL_SERVO];
  wire [31:0] err_abs = err_now[31] ? 32'(-err_now) : 32'(err_now);
  wire slip_set = tick && ctrl[qeh_pkg::CTRL_SLIP_EN] && (err_abs > slip_limit);
  wire corr_set = !servo && ctrl[qeh_pkg::CTRL_CORR_EN] && move_done;
  wire signed [47:0] gear_prod = $signed(position) * $signed(gear_ratio);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      integ <= 32'sh0;
      err_prev <= 32'sh0;
      servo_out <= '0;
    end else if (!servo) begin
      // Clearing the history avoids a kick when the axis turns servo
      integ <= 32'sh0;
      err_prev <= 32'sh0;
      servo_out <= '0;
    end else if (tick) begin
      integ <= integ + err_now;
      err_prev <= err_now;
      servo_out <= pid_sat;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      correct_valid <= 1'b0;
      correct_steps <= 32'h0000_0000;
      gear_position <= 32'h0000_0000;
    end else begin
      correct_valid <= corr_set;
      if (corr_set) begin
        correct_steps <= err_now;
      end
      gear_position <= ctrl[qeh_pkg::CTRL_GEAR_EN] ? gear_prod[31 + qeh_pkg::GEAR_SHIFT:qeh_pkg::GEAR_SHIFT]
        : 32'h0000_0000;
    end
  end

  // Position counter: home load beats a bus write, which beats counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      position <= 32'h0000_0000;
    end else if (home_found) begin
      position <= home_value;
    end else if (w_pos) begin
      position <= merge(position, s_axi_wdata, wmask);
    end else if (cnt_up) begin
      position <= position + 32'h0000_0001;
    end else if (cnt_down) begin
      position <= position - 32'h0000_0001;
    end
  end

  // Homing sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      home_state <= qeh_pkg::HOME_IDLE;
      hit_d <= 1'b0;
      stop_ramp <= 1'b0;
      stop_now <= 1'b0;
    end else begin
      hit_d <= home_hit;
      stop_ramp <= 1'b0;
      stop_now <= 1'b0;
      case (home_state)
        qeh_pkg::HOME_IDLE: begin
          if (seek_req) begin
            home_state <= qeh_pkg::HOME_SEEK;
          end
        end
        qeh_pkg::HOME_SEEK: begin
          if (abort_req) begin
            home_state <= qeh_pkg::HOME_IDLE;
          end else if (home_edge) begin
            home_state <= qeh_pkg::HOME_STOP;
            stop_now <= ctrl[qeh_pkg::CTRL_STOP_NOW];
            stop_ramp <= !ctrl[qeh_pkg::CTRL_STOP_NOW];
          end
        end
        default: begin
          home_state <= qeh_pkg::HOME_IDLE;
        end
      endcase
    end
  end

  assign homing_active = seeking;
  assign home_dir = ctrl[qeh_pkg::CTRL_DIR_NEG];

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= qeh_pkg::CTRL_RESET;
      home_value <= 32'h0000_0000;
      cmd_pos <= 32'h0000_0000;
      kp <= 16'h0000;
      ki <= 16'h0000;
      kd <= 16'h0000;
      slip_limit <= qeh_pkg::SLIP_RESET;
      gear_ratio <= qeh_pkg::GEAR_RESET;
      irq_mask <= '0;
    end else begin
      if (w_ctrl) begin
        ctrl <= qeh_pkg::CTRL_W'(merge(32'(ctrl), s_axi_wdata, wmask));
      end
      if (w_hval) begin
        home_value <= merge(home_value, s_axi_wdata, wmask);
      end
      if (w_cpos) begin
        cmd_pos <= merge(cmd_pos, s_axi_wdata, wmask);
      end
      if (w_kp) begin
        kp <= 16'(merge(32'(kp), s_axi_wdata, wmask));
      end
      if (w_ki) begin
        ki <= 16'(merge(32'(ki), s_axi_wdata, wmask));
      end
      if (w_kd) begin
        kd <= 16'(merge(32'(kd), s_axi_wdata, wmask));
      end
      if (w_slip) begin
        slip_limit <= merge(slip_limit, s_axi_wdata, wmask);
      end
      if (w_gear) begin
        gear_ratio <= 16'(merge(32'(gear_ratio), s_axi_wdata, wmask));
      end
      if (w_mask) begin
        irq_mask <= qeh_pkg::ST_W'(merge(32'(irq_mask), s_axi_wdata, wmask));
      end
    end
  end

  // Sticky events; a new event in the clearing cycle survives
  wire [qeh_pkg::ST_W-1:0] st_set = {cnt_err, corr_set, slip_set, home_found};
  wire [qeh_pkg::ST_W-1:0] st_clr = w_stat ? wbits[qeh_pkg::ST_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~st_clr) | st_set;
    end
  end

  assign irq = |(status & irq_mask);

  // Read mux
  logic [31:0] rd_mux;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    if (ra == qeh_pkg::OFF_CTRL) begin
      rd_mux = 32'(ctrl);
    end else if (ra == qeh_pkg::OFF_CMD) begin
      rd_mux = 32'h0000_0000;
    end else if (ra == qeh_pkg::OFF_POS) begin
      rd_mux = position;
    end else if (ra == qeh_pkg::OFF_HOME_VAL) begin
      rd_mux = home_value;
    end else if (ra == qeh_pkg::OFF_CMD_POS) begin
      rd_mux = cmd_pos;
    end else if (ra == qeh_pkg::OFF_ERROR) begin
      rd_mux = err_now;
    end else if (ra == qeh_pkg::OFF_KP) begin
      rd_mux = 32'(kp);
    end else if (ra == qeh_pkg::OFF_KI) begin
      rd_mux = 32'(ki);
    end else if (ra == qeh_pkg::OFF_KD) begin
      rd_mux = 32'(kd);
    end else if (ra == qeh_pkg::OFF_PID_OUT) begin
      rd_mux = 32'(servo_out);
    end else if (ra == qeh_pkg::OFF_SLIP_LIM) begin
      rd_mux = slip_limit;
    end else if (ra == qeh_pkg::OFF_GEAR) begin
      rd_mux = 32'(gear_ratio);
    end else if (ra == qeh_pkg::OFF_STATUS) begin
      rd_mux = 32'(status);
    end else if (ra == qeh_pkg::OFF_MASK) begin
      rd_mux = 32'(irq_mask);
    end else if (ra == qeh_pkg::OFF_STATE) begin
      rd_mux = {24'h000000, pins_s, 1'b0, home_state};
    end else if (ra == qeh_pkg::OFF_CORR) begin
      rd_mux = correct_steps;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Bus responses, one cycle after the handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= qeh_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= qeh_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_known ? qeh_pkg::RESP_OKAY : qeh_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_ok ? qeh_pkg::RESP_OKAY : qeh_pkg::RESP_SLVERR;
        s_axi_rdata <= rd_ok ? rd_mux : 32'h0000_0000;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : qeh_axis

// ---- bench/qeh_props.sv ----
`timescale 1ns/1ns
module qeh_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Axis
  input wire logic move_done,
  input wire logic home_dir,
  input wire logic homing_active,
  input wire logic stop_ramp,
  input wire logic stop_now,
  input wire logic correct_valid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence s_home_hit;
    stop_now || stop_ramp;
  endsequence
  a_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read response missing");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_stop_exclusive: assert property (!(stop_now && stop_ramp))
    else $error("both stop kinds at once");
  a_stop_from_seek: assert property (s_home_hit |-> $past(homing_active))
    else $error("stop without a seek");
  a_stop_single: assert property (s_home_hit |=> (!stop_now && !stop_ramp) [*2])
    else $error("stop pulse too long");
  // A short reset may clear the control word, so that edge is excused
  a_dir_held: assert property (!$past(s_axi_awvalid && s_axi_wvalid) && $past(aresetn) |-> $stable(home_dir))
    else $error("direction moved without a write");
  a_corr_cause: assert property (correct_valid |-> $past(move_done))
    else $error("correction without move end");
  a_reset_idle: assert property ($rose(aresetn) |-> !homing_active && !s_axi_bvalid)
    else $error("not idle after reset");
endmodule : qeh_props
bind qeh_axis qeh_props u_qeh_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .move_done, .home_dir, .homing_active,
  .stop_ramp, .stop_now, .correct_valid);

// ---- bench/qeh_enc_model.sv ----
`timescale 1ns/1ns
module qeh_enc_model (
  // Clock
  input wire logic aclk,
  // Encoder and home pins
  output logic enc_a,
  output logic enc_b,
  output logic enc_index,
  output logic home_switch,
  output logic home_enable_n
);
  logic [1:0] pos = 2'h0;
  logic idx_on = 1'b0;
  // Gray order 00,10,11,01 so A leads on positive moves
  assign enc_a = pos[1] ^ pos[0];
  assign enc_b = pos[1];
  // Index sits inside the A-and-B-high quadrant
  assign enc_index = idx_on && pos == 2'h2;
  initial begin
    home_switch = 1'b0;
    home_enable_n = 1'b1;
  end
  // Eleven cycles or more per edge keeps the count rate within 12 MHz
  task automatic step(input int n, input int gap);
    for (int k = 0; k < (n < 0 ? -n : n); k++) begin
      repeat (gap) @(posedge aclk);
      pos <= n < 0 ? pos - 2'h1 : pos + 2'h1;
    end
    repeat (8) @(posedge aclk);
  endtask : step
  // Both phases at once, a fault no healthy encoder makes
  task automatic jump;
    @(posedge aclk);
    pos <= pos + 2'h2;
    repeat (8) @(posedge aclk);
  endtask : jump
  // Enable is only ever held low for less than one line
  task automatic pins(input logic sw, input logic en_n, input logic idx);
    @(posedge aclk);
    home_switch <= sw;
    home_enable_n <= en_n;
    idx_on <= idx;
    repeat (6) @(posedge aclk);
  endtask : pins
endmodule : qeh_enc_model

// ---- bench/test_quadrature_encoder_homing.sv ----
`timescale 1ns/1ns
module test_quadrature_encoder_homing;
  localparam int SC = 16;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic move_done = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic home_dir, homing_active, stop_ramp, stop_now, correct_valid;
  logic enc_a, enc_b, enc_index, home_switch, home_enable_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, correct_steps, gear_position;
  logic signed [15:0] servo_out;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int hits = 0;
  logic last_now = 1'b0;

  always #4 aclk = ~aclk;

  qeh_axis #(.SAMPLE_CYCLES(SC)) u_qeh_axis (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .enc_a, .enc_b, .enc_index, .home_switch, .home_enable_n, .move_done, .servo_out, .home_dir,
    .homing_active, .stop_ramp, .stop_now, .correct_valid, .correct_steps, .gear_position, .irq);
  qeh_enc_model u_qeh_enc_model (.aclk, .enc_a, .enc_b, .enc_index, .home_switch, .home_enable_n);

  task automatic wrap_up;
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Stop pulses last one cycle, so they are counted here
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (stop_now || stop_ramp) begin
      hits <= hits + 1;
      last_now <= stop_now;
    end
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (s_axi_awready !== 1'b1);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(r));
    // Ready stays up so a following call never drives it twice in one step
    @(posedge aclk);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(32'(s_axi_rresp), 32'(r));
    chk(s_axi_rdata, e);
    @(posedge aclk);
  endtask : rc

  task automatic t_reset;
    rc(qeh_pkg::OFF_CTRL, 32'h0);
    rc(qeh_pkg::OFF_GEAR, 32'h100);
    rc(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
  endtask : t_reset

  task automatic t_count;
    wr(qeh_pkg::OFF_MASK, 32'h8);
    u_qeh_enc_model.step(8, 12);
    rc(qeh_pkg::OFF_POS, 32'h8);
    u_qeh_enc_model.step(-3, 12);
    rc(qeh_pkg::OFF_POS, 32'h5);
    u_qeh_enc_model.step(40, 11);
    rc(qeh_pkg::OFF_POS, 32'h2D);
    // Two jumps bring the phases back, whatever the decoder kept
    u_qeh_enc_model.jump();
    u_qeh_enc_model.jump();
    rc(qeh_pkg::OFF_POS, 32'h2D);
    chk(32'(irq), 32'h1);
    wr(qeh_pkg::OFF_STATUS, 32'h8);
    chk(32'(irq), 32'h0);
  endtask : t_count

  task automatic t_invert;
    logic [31:0] cfg [5] = '{32'h0, 32'h4, 32'hC, 32'h8, 32'h10};
    logic [31:0] exp [5] = '{32'h4, 32'hFFFFFFFC, 32'h4, 32'hFFFFFFFC, 32'hFFFFFFFC};
    // Parked at phases 00 and in this order, each setting change moves one phase only
    u_qeh_enc_model.step(-1, 12);
    for (int i = 0; i < 5; i++) begin
      wr(qeh_pkg::OFF_CTRL, cfg[i]);
      // A new phase setting may itself count once; let it land first
      repeat (8) @(posedge aclk);
      wr(qeh_pkg::OFF_POS, 32'h0);
      u_qeh_enc_model.step(4, 12);
      rc(qeh_pkg::OFF_POS, exp[i]);
    end
    wr(qeh_pkg::OFF_CTRL, 32'h0);
  endtask : t_invert

  task automatic t_switch;
    wr(qeh_pkg::OFF_MASK, 32'h1);
    wr(qeh_pkg::OFF_CMD, 32'h1);
    wr(qeh_pkg::OFF_CMD, 32'h2);
    chk(32'(homing_active), 32'h0);
    for (int p = 0; p < 2; p++) begin
      int h;
      h = hits;
      u_qeh_enc_model.pins(p == 0, 1'b1, 1'b0);
      wr(qeh_pkg::OFF_HOME_VAL, 32'h1230 + p);
      wr(qeh_pkg::OFF_CTRL, p == 1 ? 32'h62 : 32'h0);
      chk(32'(home_dir), 32'(p));
      // Stage stands still during the seek
      wr(qeh_pkg::OFF_CMD, 32'h1);
      chk(32'(homing_active), 32'h1);
      u_qeh_enc_model.pins(p == 1, 1'b1, 1'b0);
      rc(qeh_pkg::OFF_POS, 32'h1230 + p);
      chk(32'(hits - h), 32'h1);
      chk(32'(last_now), 32'(p));
      chk(32'(irq), 32'h1);
      wr(qeh_pkg::OFF_STATUS, 32'hF);
    end
    chk(32'(irq), 32'h0);
  endtask : t_switch

  task automatic t_index;
    int h;
    h = hits;
    wr(qeh_pkg::OFF_CTRL, 32'h1);
    wr(qeh_pkg::OFF_HOME_VAL, 32'h50);
    wr(qeh_pkg::OFF_CMD, 32'h1);
    u_qeh_enc_model.pins(1'b0, 1'b1, 1'b1);
    u_qeh_enc_model.step(6, 12);
    chk(32'(hits - h), 32'h0);
    // Enable falls while parked in the home quadrant, so no count races the load
    u_qeh_enc_model.pins(1'b0, 1'b0, 1'b1);
    u_qeh_enc_model.pins(1'b0, 1'b1, 1'b0);
    rc(qeh_pkg::OFF_POS, 32'h50);
    chk(32'(hits - h), 32'h1);
  endtask : t_index

  task automatic t_corr;
    wr(qeh_pkg::OFF_CTRL, 32'h400);
    wr(qeh_pkg::OFF_CMD_POS, 32'h64);
    wr(qeh_pkg::OFF_POS, 32'h5A);
    move_done <= 1'b1;
    @(posedge aclk);
    move_done <= 1'b0;
    #1;
    chk(32'(correct_valid), 32'h1);
    chk(correct_steps, 32'hA);
    @(posedge aclk);
    rc(qeh_pkg::OFF_CORR, 32'hA);
  endtask : t_corr

  task automatic t_servo;
    wr(qeh_pkg::OFF_SLIP_LIM, 32'h5);
    wr(qeh_pkg::OFF_GEAR, 32'h200);
    wr(qeh_pkg::OFF_KP, 32'h100);
    wr(qeh_pkg::OFF_KI, 32'h0);
    wr(qeh_pkg::OFF_KD, 32'h0);
    wr(qeh_pkg::OFF_CMD_POS, 32'h1C);
    wr(qeh_pkg::OFF_POS, 32'h8);
    wr(qeh_pkg::OFF_MASK, 32'h2);
    wr(qeh_pkg::OFF_CTRL, 32'h380);
    repeat (3 * SC) @(posedge aclk);
    chk(32'(servo_out), 32'h14);
    chk(gear_position, 32'h10);
    rc(qeh_pkg::OFF_ERROR, 32'h14);
    chk(32'(irq), 32'h1);
  endtask : t_servo

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_count();
    t_invert();
    t_switch();
    t_index();
    t_corr();
    t_servo();
    wrap_up();
  end
endmodule : test_quadrature_encoder_homing
